// File: hdl/rsmi_params.svh
`ifndef RSMI_PARAMS_SVH
`define RSMI_PARAMS_SVH

// ----------------------------------------
// link geometry
// ----------------------------------------
`define RSMI_ROW_W 13
`define RSMI_COL_W 11
`define RSMI_A10 10
`define RSMI_A11 11
`define RSMI_FULL_PAGE 12'h800

// ----------------------------------------
// mode register fields and reset
// ----------------------------------------
`define RSMI_MR_BL_LSB 0
`define RSMI_MR_LAT_LSB 4
`define RSMI_MR_RESET 13'h0020

// ----------------------------------------
// timing
// ----------------------------------------
`define RSMI_CLK_PERIOD_NS 10
`define RSMI_REF_WINDOW_MS 64
`define RSMI_REF_COUNT 8192
`define RSMI_REF_INTERVAL_CYC \
  ((`RSMI_REF_WINDOW_MS * 1000000) / (`RSMI_REF_COUNT * `RSMI_CLK_PERIOD_NS))

// ----------------------------------------
// controller register offsets
// ----------------------------------------
`define RSMI_REG_CTRL 8'h00
`define RSMI_REG_CMD 8'h04
`define RSMI_REG_WDLO 8'h08
`define RSMI_REG_WDHI 8'h0c
`define RSMI_REG_WCHK 8'h10
`define RSMI_REG_RDLO 8'h14
`define RSMI_REG_RDHI 8'h18
`define RSMI_REG_RCHK 8'h1c
`define RSMI_REG_STAT 8'h20
`define RSMI_REG_SPD 8'h24

// ----------------------------------------
// controller register fields
// ----------------------------------------
`define RSMI_CTRL_REG_MODE 0
`define RSMI_CTRL_CKE 1
`define RSMI_CTRL_LAT_LSB 2
`define RSMI_CTRL_REFEN 5
`define RSMI_CTRL_BURST_LSB 6
`define RSMI_CTRL_SA_LSB 10
`define RSMI_CTRL_RESET 32'h0000006a
`define RSMI_CMD_OP_LSB 0
`define RSMI_CMD_BA_LSB 3
`define RSMI_CMD_ADDR_LSB 5
`define RSMI_CMD_DQM_LSB 18
`define RSMI_STAT_BUSY 0
`define RSMI_STAT_RDV 1
`define RSMI_STAT_RCNT_LSB 8
`define RSMI_SPD_SCL 0
`define RSMI_SPD_SDA_LOW 1
`define RSMI_SPD_SDA_IN 2

`endif

// File: hdl/rsmi_pkg.sv
package rsmi_pkg;

  // command code {ras, cas, we}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } rsmi_cmd_t;

  typedef enum logic [2:0] {
    PWR_RUN = 3'h1,
    PWR_PDN = 3'h2,
    PWR_SREF = 3'h4
  } rsmi_pwr_t;

endpackage

// File: hdl/rsmi_if.sv
interface rsmi_if;
  logic module_select_n_first;
  logic module_select_n_second;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic clock_gate_input;
  logic bank_select_low;
  logic bank_select_high;
  logic [12:0] row_column_address;
  logic [7:0] byte_lane_masks;
  logic register_mode_select;
  logic [63:0] ctl_data;
  logic [7:0] ctl_check;
  logic ctl_data_oe;
  logic [63:0] mod_data;
  logic [7:0] mod_check;
  logic [7:0] mod_lane_oe;
  logic [63:0] data_lines;
  logic [7:0] error_check_bits;
  logic presence_detect_scl;
  logic ctl_sda_oe;
  logic mod_sda_oe;
  logic presence_detect_sda;
  logic [2:0] presence_detect_slave_addr;
  logic presence_detect_wp;

  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_lane
    assign data_lines[8*i +: 8] = mod_lane_oe[i] ? mod_data[8*i +: 8] :
                                  (ctl_data_oe ? ctl_data[8*i +: 8] : 8'h00);
    assign error_check_bits[i] = mod_lane_oe[i] ? mod_check[i] :
                                 (ctl_data_oe ? ctl_check[i] : 1'b0);
  end
  assign presence_detect_sda = ~(ctl_sda_oe | mod_sda_oe);
  assign presence_detect_wp = 1'b0;

  modport ctl_mp (
    output module_select_n_first, module_select_n_second, ras_n, cas_n, we_n,
    output clock_gate_input, bank_select_low, bank_select_high, row_column_address,
    output byte_lane_masks, register_mode_select, ctl_data, ctl_check, ctl_data_oe,
    output presence_detect_scl, ctl_sda_oe, presence_detect_slave_addr,
    input data_lines, error_check_bits, presence_detect_sda
  );

  modport mod_mp (
    input module_select_n_first, module_select_n_second, ras_n, cas_n, we_n,
    input clock_gate_input, bank_select_low, bank_select_high, row_column_address,
    input byte_lane_masks, register_mode_select, data_lines, error_check_bits,
    input presence_detect_scl, presence_detect_sda, presence_detect_slave_addr,
    input presence_detect_wp,
    output mod_data, mod_check, mod_lane_oe, mod_sda_oe
  );
endinterface

// File: hdl/rsmi_input_stage.sv
module rsmi_input_stage #(
  parameter int W = 29
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reg_mode_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] hold;
  } rsmi_stage_state_t;

  rsmi_stage_state_t st;
  rsmi_stage_state_t next_st;

  always_comb begin
    next_st.hold = d_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{hold: {W{1'b1}}};
    end else begin
      st <= next_st;
    end
  end

  // registered mode adds one edge, buffered mode passes through
  assign q_o = reg_mode_i ? st.hold : d_i;
endmodule // rsmi_input_stage

// File: hdl/rsmi_module.sv
// Summary of operation
// - registered mode: read latency is latency plus one
// - burst lengths 1, 2, 4, 8, full page
// - controller refreshes 8192 times per 64 ms
// - new column accepted every clock cycle
// - all inputs sampled on rising clock edge
// - command from select, row, column, write strobes
// - select high masks every command
// - clock gate low: power-down, self refresh, suspend
// - clock gate asynchronous while powered down
// - write lanes with mask high are discarded
// - read mask high: lane off two clocks later
// - activate carries row; access carries column, A10 auto-precharge
// - precharge: A10 low one bank, high all
// - two bank bits pick one of four banks
// - mode load: bank bits pick base or extended
// - presence detect clocked by serial clock, shared data
// - system straps three presence-detect address pins
// - register enable: one-edge capture, else pass through
// - column from A0-A9 and A11
// - write protect tied inactive on module
//
// Local design decisions: strobed register access and the placing of the registers.
`include "rsmi_params.svh"

module rsmi_module #(
  parameter int MEM_ROW_BITS = 2,
  parameter int MEM_COL_BITS = 4,
  parameter int READ_PIPE = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  rsmi_if.mod_mp link,
  output logic power_down_o,
  output logic self_refresh_o,
  output logic clock_suspended_o,
  output logic [12:0] mode_reg_o,
  output logic [12:0] ext_mode_reg_o
);
  localparam int IW = 2 + MEM_ROW_BITS + MEM_COL_BITS;
  localparam int PW = 29;

  typedef struct packed {
    rsmi_pkg::rsmi_pwr_t pwr;
    logic susp;
    logic [12:0] mode;
    logic [12:0] ext;
    logic [3:0] open;
    logic [3:0][12:0] row;
    logic burst;
    logic bwrite;
    logic [1:0] bbank;
    logic [10:0] bcol;
    logic [11:0] left;
    logic bauto;
    logic [READ_PIPE-1:0] rvalid;
    logic [READ_PIPE-1:0][71:0] rdata;
    logic [1:0][7:0] dqm_d;
  } rsmi_mod_state_t;

  rsmi_mod_state_t st;
  rsmi_mod_state_t next_st;
  logic [71:0] mem [2**IW];
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin;
  logic p_cs1_n, p_cs2_n, p_ras_n, p_cas_n, p_we_n, p_cke;
  logic [1:0] p_ba;
  logic [12:0] p_addr;
  logic [7:0] p_dqm;
  rsmi_pkg::rsmi_cmd_t cmd;
  logic beat;
  logic beat_wr;
  logic [1:0] beat_bank;
  logic [10:0] beat_col;
  logic [IW-1:0] beat_idx;
  logic [71:0] wr_word;
  logic [2:0] lat;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic rsmi_pkg::rsmi_cmd_t decode(input logic s1_n, input logic s2_n,
                                                 input logic [2:0] rcw);
    if (s1_n || s2_n) begin
      return rsmi_pkg::CMD_NOP;
    end
    return rsmi_pkg::rsmi_cmd_t'(rcw);
  endfunction

  function automatic logic [11:0] burst_beats(input logic [2:0] code);
    unique case (code)
      3'h0: return 12'h001;
      3'h1: return 12'h002;
      3'h2: return 12'h004;
      3'h3: return 12'h008;
      3'h7: return `RSMI_FULL_PAGE;
      default: return 12'h001;
    endcase
  endfunction

  function automatic logic [10:0] next_col(input logic [10:0] col, input logic [11:0] n);
    logic [10:0] m;
    m = 11'(n - 12'h001);
    return (col & ~m) | (11'(col + 11'h001) & m);
  endfunction

  // ----------------------------------------
  // input stage
  // ----------------------------------------
  assign pin_raw = {link.module_select_n_first, link.module_select_n_second,
                    link.ras_n, link.cas_n, link.we_n,
                    link.bank_select_high, link.bank_select_low,
                    link.row_column_address, link.byte_lane_masks,
                    link.clock_gate_input};

  rsmi_input_stage #(
    .W(PW)
  ) u_stage (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .reg_mode_i(link.register_mode_select),
    .d_i(pin_raw),
    .q_o(pin)
  );

  assign {p_cs1_n, p_cs2_n, p_ras_n, p_cas_n, p_we_n, p_ba, p_addr, p_dqm, p_cke} = pin;
  assign cmd = decode(p_cs1_n, p_cs2_n, {p_ras_n, p_cas_n, p_we_n});
  assign lat = (st.mode[`RSMI_MR_LAT_LSB +: 3] == 3'h0) ? 3'h1 : st.mode[`RSMI_MR_LAT_LSB +: 3];
  assign wr_word = {link.error_check_bits, link.data_lines};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    beat = 1'b0;
    beat_wr = 1'b0;
    beat_bank = st.bbank;
    beat_col = st.bcol;
    beat_idx = '0;
    if (st.pwr != rsmi_pkg::PWR_RUN) begin
      // only the raw clock gate pin is watched here
      if (link.clock_gate_input) begin
        next_st.pwr = rsmi_pkg::PWR_RUN;
      end
    end else if (!p_cke) begin
      if (st.burst || (|st.rvalid)) begin
        next_st.susp = 1'b1;
      end else if (cmd == rsmi_pkg::CMD_REF) begin
        next_st.pwr = rsmi_pkg::PWR_SREF;
      end else begin
        next_st.pwr = rsmi_pkg::PWR_PDN;
      end
    end else begin
      next_st.susp = 1'b0;
      next_st.rvalid = {st.rvalid[READ_PIPE-2:0], 1'b0};
      next_st.rdata = {st.rdata[READ_PIPE-2:0], 72'h0};
      next_st.dqm_d = {st.dqm_d[0], p_dqm};
      if (cmd == rsmi_pkg::CMD_RD || cmd == rsmi_pkg::CMD_WR) begin
        // a new access cuts any running burst short
        beat = 1'b1;
        beat_wr = (cmd == rsmi_pkg::CMD_WR);
        beat_bank = p_ba;
        beat_col = {p_addr[`RSMI_A11], p_addr[9:0]};
        next_st.bwrite = beat_wr;
        next_st.bbank = p_ba;
        next_st.bauto = p_addr[`RSMI_A10];
        next_st.left = 12'(burst_beats(st.mode[`RSMI_MR_BL_LSB +: 3]) - 12'h001);
      end else if (st.burst) begin
        beat = 1'b1;
        beat_wr = st.bwrite;
        next_st.left = 12'(st.left - 12'h001);
      end
      if (beat) begin
        beat_idx = {beat_bank, st.row[beat_bank][MEM_ROW_BITS-1:0],
                    beat_col[MEM_COL_BITS-1:0]};
        next_st.bcol = next_col(beat_col, burst_beats(st.mode[`RSMI_MR_BL_LSB +: 3]));
        next_st.burst = (next_st.left != 12'h000);
        if (!beat_wr) begin
          next_st.rvalid[0] = 1'b1;
          next_st.rdata[0] = mem[beat_idx];
        end
        if (!next_st.burst && next_st.bauto) begin
          next_st.open[beat_bank] = 1'b0;
        end
      end
      unique case (cmd)
        rsmi_pkg::CMD_ACT: begin
          next_st.open[p_ba] = 1'b1;
          next_st.row[p_ba] = p_addr;
        end
        rsmi_pkg::CMD_PRE: begin
          if (p_addr[`RSMI_A10]) begin
            next_st.open = 4'h0;
          end else begin
            next_st.open[p_ba] = 1'b0;
          end
        end
        rsmi_pkg::CMD_LMR: begin
          if (p_ba == 2'h0) begin
            next_st.mode = p_addr;
          end else if (p_ba == 2'h1) begin
            next_st.ext = p_addr;
          end
        end
        rsmi_pkg::CMD_BST: begin
          next_st.burst = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // state and array
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{pwr: rsmi_pkg::PWR_RUN, mode: `RSMI_MR_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (beat && beat_wr && st.pwr == rsmi_pkg::PWR_RUN && p_cke) begin
      for (int i = 0; i < 8; i++) begin
        if (!p_dqm[i]) begin
          mem[beat_idx][8*i +: 8] <= wr_word[8*i +: 8];
          mem[beat_idx][64+i] <= wr_word[64+i];
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.mod_data = st.rdata[lat-1][63:0];
  assign link.mod_check = st.rdata[lat-1][71:64];
  for (genvar i = 0; i < 8; i++) begin : g_oe
    assign link.mod_lane_oe[i] = st.rvalid[lat-1] & ~st.dqm_d[1][i];
  end
  // presence-detect storage is not modelled: the line is only released
  assign link.mod_sda_oe = 1'b0;
  assign power_down_o = (st.pwr == rsmi_pkg::PWR_PDN);
  assign self_refresh_o = (st.pwr == rsmi_pkg::PWR_SREF);
  assign clock_suspended_o = st.susp;
  assign mode_reg_o = st.mode;
  assign ext_mode_reg_o = st.ext;
endmodule // rsmi_module

// File: hdl/rsmi_ctrl.sv
`include "rsmi_params.svh"

module rsmi_ctrl #(
  parameter int REF_INTERVAL = `RSMI_REF_INTERVAL_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  rsmi_if.ctl_mp link,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic cs_n;
    logic [2:0] op;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [7:0] dqm;
    logic [71:0] wdata;
    logic oe;
    logic wdly;
    logic [3:0] wleft;
    logic [4:0] rwait;
    logic [3:0] rleft;
    logic [71:0] rdata;
    logic rdv;
    logic [7:0] rcnt;
    logic [1:0] spd;
    logic [15:0] refcnt;
    logic refpend;
    logic [31:0] rd;
  } rsmi_ctl_state_t;

  rsmi_ctl_state_t st;
  rsmi_ctl_state_t next_st;
  logic busy;
  logic wr_cmd;
  logic cap;
  logic [3:0] burst;

  assign busy = st.wdly | (st.wleft != 4'h0) | (st.rwait != 5'h00) | (st.rleft != 4'h0);
  assign wr_cmd = reg_wr_i && (reg_addr_i == `RSMI_REG_CMD);
  assign cap = (st.rwait == 5'h01) || (st.rwait == 5'h00 && st.rleft != 4'h0);
  assign burst = st.ctrl[`RSMI_CTRL_BURST_LSB +: 4];

  always_comb begin
    next_st = st;
    // idle cycles deselect the module
    next_st.cs_n = 1'b1;
    next_st.op = rsmi_pkg::CMD_NOP;
    next_st.oe = 1'b0;
    // ----------------------------------------
    // write data beats
    // ----------------------------------------
    if (st.wdly) begin
      next_st.wdly = 1'b0;
      next_st.oe = 1'b1;
      next_st.wleft = 4'(st.wleft - 4'h1);
    end else if (st.wleft != 4'h0) begin
      next_st.oe = 1'b1;
      next_st.wleft = 4'(st.wleft - 4'h1);
    end
    // ----------------------------------------
    // read capture
    // ----------------------------------------
    if (cap) begin
      next_st.rdata = {link.error_check_bits, link.data_lines};
      next_st.rdv = 1'b1;
      next_st.rcnt = 8'(st.rcnt + 8'h01);
      if (st.rwait == 5'h01) begin
        next_st.rwait = 5'h00;
      end else begin
        next_st.rleft = 4'(st.rleft - 4'h1);
      end
    end else if (st.rwait > 5'h01) begin
      next_st.rwait = 5'(st.rwait - 5'h01);
    end
    // ----------------------------------------
    // refresh timer
    // ----------------------------------------
    if (st.refcnt == 16'h0000) begin
      next_st.refcnt = 16'(REF_INTERVAL - 1);
      next_st.refpend = st.ctrl[`RSMI_CTRL_REFEN];
    end else begin
      next_st.refcnt = 16'(st.refcnt - 16'h0001);
    end
    if (st.refpend && !wr_cmd && !busy) begin
      next_st.cs_n = 1'b0;
      next_st.op = rsmi_pkg::CMD_REF;
      next_st.refpend = 1'b0;
    end
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RSMI_REG_CTRL: next_st.ctrl = reg_wdata_i;
        `RSMI_REG_WDLO: next_st.wdata[31:0] = reg_wdata_i;
        `RSMI_REG_WDHI: next_st.wdata[63:32] = reg_wdata_i;
        `RSMI_REG_WCHK: next_st.wdata[71:64] = reg_wdata_i[7:0];
        `RSMI_REG_SPD: next_st.spd = reg_wdata_i[1:0];
        `RSMI_REG_CMD: begin
          next_st.cs_n = 1'b0;
          next_st.op = reg_wdata_i[`RSMI_CMD_OP_LSB +: 3];
          next_st.ba = reg_wdata_i[`RSMI_CMD_BA_LSB +: 2];
          next_st.addr = reg_wdata_i[`RSMI_CMD_ADDR_LSB +: 13];
          next_st.dqm = reg_wdata_i[`RSMI_CMD_DQM_LSB +: 8];
          if (next_st.op == rsmi_pkg::CMD_WR) begin
            if (st.ctrl[`RSMI_CTRL_REG_MODE]) begin
              next_st.wdly = 1'b1;
              next_st.wleft = burst;
            end else begin
              next_st.oe = 1'b1;
              next_st.wleft = 4'(burst - 4'h1);
            end
          end
          if (next_st.op == rsmi_pkg::CMD_RD) begin
            next_st.rwait = 5'(st.ctrl[`RSMI_CTRL_LAT_LSB +: 3] + 3'h1 +
                               st.ctrl[`RSMI_CTRL_REG_MODE]);
            next_st.rleft = 4'(burst - 4'h1);
          end
        end
        default: begin
        end
      endcase
    end
    // ----------------------------------------
    // register reads
    // ----------------------------------------
    next_st.rd = 32'h00000000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RSMI_REG_CTRL: next_st.rd = st.ctrl;
        `RSMI_REG_WDLO: next_st.rd = st.wdata[31:0];
        `RSMI_REG_WDHI: next_st.rd = st.wdata[63:32];
        `RSMI_REG_WCHK: next_st.rd = {24'h000000, st.wdata[71:64]};
        `RSMI_REG_RDLO: begin
          next_st.rd = st.rdata[31:0];
          next_st.rdv = cap; // set wins over clear
        end
        `RSMI_REG_RDHI: next_st.rd = st.rdata[63:32];
        `RSMI_REG_RCHK: next_st.rd = {24'h000000, st.rdata[71:64]};
        `RSMI_REG_STAT: next_st.rd = {16'h0000, st.rcnt, 6'h00, st.rdv, busy};
        `RSMI_REG_SPD: next_st.rd = {29'h00000000, link.presence_detect_sda, st.spd};
        default: next_st.rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{ctrl: `RSMI_CTRL_RESET, cs_n: 1'b1, op: 3'h7, spd: 2'h1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign link.module_select_n_first = st.cs_n;
  assign link.module_select_n_second = st.cs_n;
  assign {link.ras_n, link.cas_n, link.we_n} = st.op;
  assign link.bank_select_low = st.ba[0];
  assign link.bank_select_high = st.ba[1];
  assign link.row_column_address = st.addr;
  assign link.byte_lane_masks = st.dqm;
  assign link.clock_gate_input = st.ctrl[`RSMI_CTRL_CKE];
  assign link.register_mode_select = st.ctrl[`RSMI_CTRL_REG_MODE];
  assign link.ctl_data = st.wdata[63:0];
  assign link.ctl_check = st.wdata[71:64];
  assign link.ctl_data_oe = st.oe;
  assign link.presence_detect_scl = st.spd[`RSMI_SPD_SCL];
  assign link.ctl_sda_oe = st.spd[`RSMI_SPD_SDA_LOW];
  assign link.presence_detect_slave_addr = st.ctrl[`RSMI_CTRL_SA_LSB +: 3];
  assign reg_rdata_o = st.rd;
endmodule // rsmi_ctrl

// File: tb/rsmi_properties.sv
module rsmi_properties (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic module_select_n_first,
  input wire logic module_select_n_second,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic clock_gate_input,
  input wire logic [7:0] byte_lane_masks,
  input wire logic register_mode_select,
  input wire logic ctl_data_oe,
  input wire logic [7:0] mod_lane_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic sel;
  logic rd_sel;
  assign sel = !module_select_n_first && !module_select_n_second;
  assign rd_sel = sel && {ras_n, cas_n, we_n} == rsmi_pkg::CMD_RD;
  sequence s_rd;
    rd_sel && clock_gate_input && byte_lane_masks == 8'h00;
  endsequence
  sequence s_wr;
    sel && {ras_n, cas_n, we_n} == rsmi_pkg::CMD_WR;
  endsequence
  AST_RD_BUF: assert property (
    s_rd ##0 !register_mode_select |-> ##2 mod_lane_oe == 8'hff)
    else $error("buffered read beat late");
  AST_RD_REG: assert property (
    s_rd ##0 register_mode_select |=> ##2 mod_lane_oe == 8'hff)
    else $error("registered read beat late");
  AST_MASK_BUF: assert property (
    !register_mode_select && clock_gate_input && byte_lane_masks[0] |-> ##2 !mod_lane_oe[0])
    else $error("masked lane still driven");
  AST_MASK_REG: assert property (
    register_mode_select && $past(register_mode_select) && clock_gate_input
    && byte_lane_masks[0] |=> ##2 !mod_lane_oe[0])
    else $error("registered mask lane still driven");
  AST_SEL_NOP: assert property (
    module_select_n_first |-> {ras_n, cas_n, we_n} == rsmi_pkg::CMD_NOP)
    else $error("deselected cycle without no-op");
  AST_WR_OE_BUF: assert property (
    s_wr ##0 !register_mode_select |-> ctl_data_oe)
    else $error("buffered write data not driven");
  AST_WR_OE_REG: assert property (
    s_wr ##0 register_mode_select |=> ctl_data_oe)
    else $error("registered write data not driven");
  AST_LANE_CAUSE: assert property (
    $rose(mod_lane_oe[1]) |-> $past(rd_sel, 2) || $past(rd_sel, 3))
    else $error("lane driven without read");
endmodule // rsmi_properties

// File: tb/rsmi_tb_top.sv
`include "rsmi_params.svh"

module rsmi_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [31:0] rwd = 32'h0;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [31:0] rdat;
  logic pdn;
  logic sref;
  logic susp;
  logic [12:0] mr;
  logic [12:0] emr;
  logic [31:0] v;
  int fails = 0;
  int check_count = 0;
  int beats = 0;
  int refs = 0;
  always #5 clk_i = ~clk_i;
  rsmi_if u_rsmi_if ();
  rsmi_ctrl #(.REF_INTERVAL(20)) u_rsmi_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .link(u_rsmi_if),
    .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat));
  rsmi_module u_rsmi_module (.clk_i(clk_i), .nrst_i(nrst_i), .link(u_rsmi_if),
    .power_down_o(pdn), .self_refresh_o(sref), .clock_suspended_o(susp), .mode_reg_o(mr),
    .ext_mode_reg_o(emr));
  rsmi_properties u_rsmi_properties (.clk_i(clk_i), .nrst_i(nrst_i),
    .module_select_n_first(u_rsmi_if.module_select_n_first),
    .module_select_n_second(u_rsmi_if.module_select_n_second),
    .ras_n(u_rsmi_if.ras_n), .cas_n(u_rsmi_if.cas_n), .we_n(u_rsmi_if.we_n),
    .clock_gate_input(u_rsmi_if.clock_gate_input), .byte_lane_masks(u_rsmi_if.byte_lane_masks),
    .register_mode_select(u_rsmi_if.register_mode_select), .ctl_data_oe(u_rsmi_if.ctl_data_oe),
    .mod_lane_oe(u_rsmi_if.mod_lane_oe));
  // ----------------------------------------
  // link counters and bus tasks
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (u_rsmi_if.mod_lane_oe == 8'hff) begin
      beats <= beats + 1;
    end
    if (!u_rsmi_if.module_select_n_first && !u_rsmi_if.ras_n && !u_rsmi_if.cas_n
        && u_rsmi_if.we_n) begin
      refs <= refs + 1;
    end
  end
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    rwr <= w;
    rrd <= r;
    ra <= a;
    rwd <= d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, 1'b1, a, 32'h0);
    q = rdat;
  endtask
  task automatic idle(input int c);
    repeat (c) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a,
                     input logic [7:0] m);
    wr(`RSMI_REG_CMD, {6'h00, m, a, ba, op});
    idle(12);
  endtask
  task automatic put(input logic [71:0] w);
    wr(`RSMI_REG_WDLO, w[31:0]);
    wr(`RSMI_REG_WDHI, w[63:32]);
    wr(`RSMI_REG_WCHK, {24'h0, w[71:64]});
  endtask
  task automatic get(input logic [1:0] ba, input logic [7:0] m, input string what,
                     input logic [71:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] ck;
    cmd(rsmi_pkg::CMD_RD, ba, 13'h0005, m);
    rd(`RSMI_REG_RDLO, lo);
    rd(`RSMI_REG_RDHI, hi);
    rd(`RSMI_REG_RCHK, ck);
    chk(what, exp, {ck[7:0], hi, lo});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    rd(`RSMI_REG_CTRL, v);
    chk("ctrl reset", `RSMI_CTRL_RESET, v);
    chk("mode reset", `RSMI_MR_RESET, mr);
    rd(`RSMI_REG_SPD, v);
    chk("presence idle", 72'h5, v);
    wr(`RSMI_REG_SPD, 32'h2);
    rd(`RSMI_REG_SPD, v);
    chk("presence low", 72'h2, v);
    wr(`RSMI_REG_CTRL, 32'h4a);
    cmd(rsmi_pkg::CMD_LMR, 2'h1, 13'h0155, 8'h00);
    chk("ext mode", 13'h0155, emr);
    cmd(rsmi_pkg::CMD_ACT, 2'h1, 13'h0003, 8'h00);
    cmd(rsmi_pkg::CMD_ACT, 2'h2, 13'h0003, 8'h00);
    put(72'h11_0123456789abcdef);
    cmd(rsmi_pkg::CMD_WR, 2'h1, 13'h0005, 8'h00);
    put(72'h22_fedcba9876543210);
    cmd(rsmi_pkg::CMD_WR, 2'h2, 13'h0005, 8'h00);
    put(72'h44_aaaaaaaaaaaaaaaa);
    cmd(rsmi_pkg::CMD_WR, 2'h1, 13'h0005, 8'h01);
    get(2'h1, 8'h00, "masked write", 72'h45_aaaaaaaaaaaaaaef);
    get(2'h2, 8'h00, "bank two", 72'h22_fedcba9876543210);
    get(2'h2, 8'h01, "masked read", 72'h22_fedcba9876543200);
    wr(`RSMI_REG_CTRL, 32'h4b);
    put(72'h33_0f0f0f0f0f0f0f0f);
    cmd(rsmi_pkg::CMD_WR, 2'h2, 13'h0005, 8'h00);
    get(2'h2, 8'h00, "registered read", 72'h33_0f0f0f0f0f0f0f0f);
    get(2'h2, 8'h01, "registered mask", 72'h32_0f0f0f0f0f0f0f00);
    for (int i = 0; i < 4; i++) begin
      cmd(rsmi_pkg::CMD_PRE, 2'h0, 13'h0400, 8'h00);
      cmd(rsmi_pkg::CMD_LMR, 2'h0, 13'h0020 | 13'(i), 8'h00);
      chk("mode load", 13'h0020 | 13'(i), mr);
      cmd(rsmi_pkg::CMD_ACT, 2'h2, 13'h0003, 8'h00);
      wr(`RSMI_REG_CTRL, 32'h0a | (32'h1 << (6 + i)));
      beats = 0;
      cmd(rsmi_pkg::CMD_RD, 2'h2, 13'h0005, 8'h00);
      chk("burst beats", 72'(1 << i), 72'(beats));
    end
    rd(`RSMI_REG_STAT, v);
    chk("status", 72'h1402, v);
    cmd(rsmi_pkg::CMD_PRE, 2'h0, 13'h0400, 8'h00);
    wr(`RSMI_REG_CTRL, 32'h48);
    idle(4);
    chk("power down", 72'h1, {71'h0, pdn});
    chk("no self refresh", 72'h0, {71'h0, sref});
    chk("no suspend", 72'h0, {71'h0, susp});
    wr(`RSMI_REG_CTRL, 32'h4a);
    idle(4);
    chk("power up", 72'h0, {71'h0, pdn});
    wr(`RSMI_REG_CTRL, 32'h146a);
    refs = 0;
    idle(100);
    chk("refresh count", 72'h1, {71'h0, refs inside {[4:6]}});
    chk("slave addr", 72'h5, 72'(u_rsmi_if.presence_detect_slave_addr));
    report_and_stop();
  end
endmodule // rsmi_tb_top
